// file: tm8_consts.svh
// Constants of the 8-bit waveform timer: offsets, fields, levels, codes
// Function
// - Mode 0 only counts up and wraps 0xFF to 0x00, never cleared.
// - Normal mode sets overflow flag as counter becomes zero; never clears.
// - Mode 2 clears counter on match with compare A; A is top.
// - Clear-on-match compare A unbuffered; value below count waits for wrap.
// - Clear-on-match with action 1 toggles output A on every match.
// - Clear-on-match sets overflow flag when counter passes maximum to 0x00.
// - Modes 3 and 7 are fast PWM; top 0xFF or compare A.
// - Fast PWM counts up to top, then clears on next timer tick.
// - Fast PWM action 2 clears on match, sets at wrap; 3 inverts.
// - Fast PWM sets overflow flag each time counter reaches top.
// - Fast PWM compare zero: one-tick spike; maximum: constant level.
// - Fast PWM action 1 toggles on match; compare stays double buffered.
// - Modes 1 and 5 are phase-correct PWM; top 0xFF or compare A.
// - Phase-correct reverses at top and holds top one timer tick.
// - Phase-correct action 2 clears on up match, sets on down; 3 inverts.
// - Phase-correct sets overflow flag each time counter reaches zero.
// - Phase-correct non-inverted: compare zero stays low, maximum high.
// - Phase-correct output takes up-match level at zero after missed match.
// - Output action fields never change the counting sequence.
// - Non-PWM modes set, clear or toggle output on compare match.
// - Timer tick divides clock by 1, 8, 32, 64, 128, 256, 1024.
// - Compare output reaches pin only when pin direction is output.
// - PWM modes buffer compare values; other modes write them directly.
// - Counter equal to compare sets compare flag on next timer tick.
// - Clock select zero stops counter; software count write wins.
`ifndef TM8_CONSTS_SVH
`define TM8_CONSTS_SVH

`define TM8_ADDR_W 3
`define TM8_REG_CTRL 3'h0
`define TM8_REG_ACTION 3'h1
`define TM8_REG_COUNT 3'h2
`define TM8_REG_CMPA 3'h3
`define TM8_REG_CMPB 3'h4
`define TM8_REG_FLAGS 3'h5
`define TM8_REG_PINDIR 3'h6
`define TM8_REG_STATUS 3'h7

`define TM8_CTRL_MODE_LSB 0
`define TM8_CTRL_CS_LSB 3
`define TM8_ACTION_A_LSB 0
`define TM8_ACTION_B_LSB 2
`define TM8_FLAG_OVF 0
`define TM8_FLAG_CFA 1
`define TM8_FLAG_CFB 2
`define TM8_PIN_A 0
`define TM8_PIN_B 1

`define TM8_MAX 8'hFF
`define TM8_BOTTOM 8'h00
`define TM8_PRE_W 10

`define TM8_ACT_NONE 2'h0
`define TM8_ACT_TOGGLE 2'h1
`define TM8_ACT_CLEAR 2'h2
`define TM8_ACT_SET 2'h3

`define TM8_DIV1_MASK 10'h000
`define TM8_DIV8_MASK 10'h007
`define TM8_DIV32_MASK 10'h01F
`define TM8_DIV64_MASK 10'h03F
`define TM8_DIV128_MASK 10'h07F
`define TM8_DIV256_MASK 10'h0FF
`define TM8_DIV1024_MASK 10'h3FF

`endif

// file: tm8_pkg.sv
// Types of the 8-bit waveform timer
`include "tm8_consts.svh"
package tm8_pkg;

  typedef enum logic [2:0] {
    TM8_NORMAL = 3'h0,
    TM8_PC_FF = 3'h1,
    TM8_CTC = 3'h2,
    TM8_FAST_FF = 3'h3,
    TM8_RSV4 = 3'h4,
    TM8_PC_CMPA = 3'h5,
    TM8_RSV6 = 3'h6,
    TM8_FAST_CMPA = 3'h7
  } tm8_wgm_t;

  typedef enum logic {
    TM8_UP = 1'b0,
    TM8_DOWN = 1'b1
  } tm8_dir_t;

  typedef struct packed {
    logic [7:0] counter_value;
    logic [7:0] cmp_a_buf;
    logic [7:0] cmp_b_buf;
    logic [7:0] cmp_a_act;
    logic [7:0] cmp_b_act;
    tm8_wgm_t waveform_mode_select;
    logic [2:0] clock_select;
    logic [1:0] compare_output_action_a;
    logic [1:0] compare_output_action_b;
    logic [2:0] flags;
    logic [1:0] pin_dir;
    logic oc_a;
    logic oc_b;
    tm8_dir_t dir;
    logic block;
    logic sym_a;
    logic sym_b;
    logic [`TM8_PRE_W-1:0] pre;
    logic [7:0] rdata;
  } tm8_state_t;

endpackage

// file: tm8_timer.sv
// 8-bit timer/counter with two compare channels and waveform modes
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ns
`include "tm8_consts.svh"
module tm8_timer
  import tm8_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Register port
  input wire logic [`TM8_ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [7:0] rdata_o,
  // Compare output pins
  output logic compare_output_a_o,
  output logic compare_output_a_oe_o,
  output logic compare_output_b_o,
  output logic compare_output_b_oe_o,
  // Flag levels
  output logic overflow_flag_o,
  output logic compare_flag_a_o,
  output logic compare_flag_b_o
);

  tm8_state_t s;
  tm8_state_t next_s;

  logic tick;
  logic cnt_wr;
  logic is_fast;
  logic is_pc;
  logic is_plain;
  logic [7:0] top;
  logic [7:0] cmp_a;
  logic [7:0] cmp_b;
  logic match_a;
  logic match_b;
  logic at_top;
  logic at_bottom;
  logic dn_match;
  logic [`TM8_PRE_W-1:0] pre_mask;

  // Next compare output level for one channel on a timer tick
  function automatic logic oc_next(
    input tm8_wgm_t m,
    input logic [1:0] act,
    input logic oc,
    input logic match,
    input logic wrap,
    input logic down_match,
    input logic fix
  );
    logic r;
    r = oc;
    case (m)
      TM8_NORMAL, TM8_CTC: begin
        if (match) begin
          case (act)
            `TM8_ACT_TOGGLE: r = ~oc;
            `TM8_ACT_CLEAR: r = 1'b0;
            `TM8_ACT_SET: r = 1'b1;
            default: r = oc;
          endcase
        end
      end
      TM8_FAST_FF, TM8_FAST_CMPA: begin
        case (act)
          `TM8_ACT_TOGGLE: begin
            if (match) r = ~oc;
          end
          `TM8_ACT_CLEAR: begin
            if (match) r = 1'b0;
            // Wrap after match so compare at top stays high
            if (wrap) r = 1'b1;
          end
          `TM8_ACT_SET: begin
            if (match) r = 1'b1;
            if (wrap) r = 1'b0;
          end
          default: r = oc;
        endcase
      end
      TM8_PC_FF, TM8_PC_CMPA: begin
        case (act)
          `TM8_ACT_TOGGLE: begin
            if (match) r = ~oc;
          end
          `TM8_ACT_CLEAR: begin
            // Match at top counts as down, at zero as up
            if (match) r = down_match;
            if (fix) r = 1'b0;
          end
          `TM8_ACT_SET: begin
            if (match) r = ~down_match;
            if (fix) r = 1'b1;
          end
          default: r = oc;
        endcase
      end
      default: r = oc;
    endcase
    return r;
  endfunction

  // Prescaler mask per clock select
  always_comb begin
    case (s.clock_select)
      3'h1: pre_mask = `TM8_DIV1_MASK;
      3'h2: pre_mask = `TM8_DIV8_MASK;
      3'h3: pre_mask = `TM8_DIV32_MASK;
      3'h4: pre_mask = `TM8_DIV64_MASK;
      3'h5: pre_mask = `TM8_DIV128_MASK;
      3'h6: pre_mask = `TM8_DIV256_MASK;
      3'h7: pre_mask = `TM8_DIV1024_MASK;
      default: pre_mask = `TM8_DIV1_MASK;
    endcase
  end

  // Clock select zero gives no tick at all
  assign tick = (s.clock_select != 3'h0) &&
                ((s.pre & pre_mask) == `TM8_DIV1_MASK);
  assign cnt_wr = we_i && (addr_i == `TM8_REG_COUNT);

  // Counting depends on mode only, never on the action fields
  assign is_fast = (s.waveform_mode_select == TM8_FAST_FF) ||
                   (s.waveform_mode_select == TM8_FAST_CMPA);
  assign is_pc = (s.waveform_mode_select == TM8_PC_FF) ||
                 (s.waveform_mode_select == TM8_PC_CMPA);
  assign is_plain = (s.waveform_mode_select == TM8_NORMAL) ||
                    (s.waveform_mode_select == TM8_CTC);
  assign top = ((s.waveform_mode_select == TM8_FAST_CMPA) ||
                (s.waveform_mode_select == TM8_PC_CMPA)) ?
               s.cmp_a_act : `TM8_MAX;

  // Non-PWM modes compare against the written value directly
  assign cmp_a = is_plain ? s.cmp_a_buf : s.cmp_a_act;
  assign cmp_b = is_plain ? s.cmp_b_buf : s.cmp_b_act;

  // A count write masks the matches of the following tick
  assign match_a = (s.counter_value == cmp_a) && !s.block;
  assign match_b = (s.counter_value == cmp_b) && !s.block;
  assign at_top = (s.counter_value == top);
  assign at_bottom = (s.counter_value == `TM8_BOTTOM);
  assign dn_match = !at_bottom && ((s.dir == TM8_DOWN) || at_top);

  always_comb begin
    next_s = s;
    // Write one clears, ahead of the tick so a same-cycle set wins
    if (we_i && (addr_i == `TM8_REG_FLAGS)) begin
      next_s.flags = s.flags & ~wdata_i[2:0];
    end
    next_s.rdata = 8'h00;
    if (s.clock_select == 3'h0) begin
      next_s.pre = '0;
    end else begin
      next_s.pre = s.pre + 1'b1;
    end

    if (tick) begin
      next_s.block = 1'b0;
      if (match_a) next_s.flags[`TM8_FLAG_CFA] = 1'b1;
      if (match_b) next_s.flags[`TM8_FLAG_CFB] = 1'b1;
      next_s.oc_a = oc_next(s.waveform_mode_select,
                            s.compare_output_action_a, s.oc_a, match_a,
                            is_fast && at_top, dn_match,
                            is_pc && (s.dir == TM8_DOWN) && at_bottom &&
                            s.sym_a);
      next_s.oc_b = oc_next(s.waveform_mode_select,
                            s.compare_output_action_b, s.oc_b, match_b,
                            is_fast && at_top, dn_match,
                            is_pc && (s.dir == TM8_DOWN) && at_bottom &&
                            s.sym_b);
      case (s.waveform_mode_select)
        TM8_NORMAL: begin
          next_s.counter_value = s.counter_value + 8'h01;
          if (s.counter_value == `TM8_MAX) begin
            next_s.flags[`TM8_FLAG_OVF] = 1'b1;
          end
        end
        TM8_CTC: begin
          if (match_a) begin
            next_s.counter_value = `TM8_BOTTOM;
          end else begin
            // Missed top runs on through 0xFF
            next_s.counter_value = s.counter_value + 8'h01;
          end
          if (s.counter_value == `TM8_MAX) begin
            next_s.flags[`TM8_FLAG_OVF] = 1'b1;
          end
        end
        TM8_FAST_FF, TM8_FAST_CMPA: begin
          if (at_top) begin
            next_s.counter_value = `TM8_BOTTOM;
            next_s.flags[`TM8_FLAG_OVF] = 1'b1;
            next_s.cmp_a_act = s.cmp_a_buf;
            next_s.cmp_b_act = s.cmp_b_buf;
          end else begin
            next_s.counter_value = s.counter_value + 8'h01;
          end
        end
        TM8_PC_FF, TM8_PC_CMPA: begin
          if (s.dir == TM8_UP) begin
            if (at_top) begin
              // Reverse here; top is seen for this one tick only
              next_s.dir = TM8_DOWN;
              next_s.counter_value = at_bottom ? `TM8_BOTTOM :
                                     s.counter_value - 8'h01;
              next_s.cmp_a_act = s.cmp_a_buf;
              next_s.cmp_b_act = s.cmp_b_buf;
              // Leaving maximum needs a fix at zero
              if (s.cmp_a_act == `TM8_MAX && s.cmp_a_buf != `TM8_MAX) begin
                next_s.sym_a = 1'b1;
              end
              if (s.cmp_b_act == `TM8_MAX && s.cmp_b_buf != `TM8_MAX) begin
                next_s.sym_b = 1'b1;
              end
            end else begin
              next_s.counter_value = s.counter_value + 8'h01;
            end
          end else begin
            if (at_bottom) begin
              next_s.dir = TM8_UP;
              next_s.counter_value = s.counter_value + 8'h01;
              next_s.flags[`TM8_FLAG_OVF] = 1'b1;
              next_s.sym_a = 1'b0;
              next_s.sym_b = 1'b0;
            end else begin
              next_s.counter_value = s.counter_value - 8'h01;
            end
          end
        end
        default: begin
          // Reserved selections keep the counter still
          next_s.counter_value = s.counter_value;
        end
      endcase
    end

    // Software access; count write beats any tick update
    if (we_i) begin
      case (addr_i)
        `TM8_REG_CTRL: begin
          next_s.waveform_mode_select =
            tm8_wgm_t'(wdata_i[`TM8_CTRL_MODE_LSB +: 3]);
          next_s.clock_select = wdata_i[`TM8_CTRL_CS_LSB +: 3];
        end
        `TM8_REG_ACTION: begin
          next_s.compare_output_action_a = wdata_i[`TM8_ACTION_A_LSB +: 2];
          next_s.compare_output_action_b = wdata_i[`TM8_ACTION_B_LSB +: 2];
        end
        `TM8_REG_COUNT: begin
          next_s.counter_value = wdata_i;
          next_s.block = 1'b1;
          // Started above compare: up match will be missed
          if (is_pc && wdata_i > s.cmp_a_act) next_s.sym_a = 1'b1;
          if (is_pc && wdata_i > s.cmp_b_act) next_s.sym_b = 1'b1;
        end
        `TM8_REG_CMPA: begin
          next_s.cmp_a_buf = wdata_i;
          if (is_plain) next_s.cmp_a_act = wdata_i;
        end
        `TM8_REG_CMPB: begin
          next_s.cmp_b_buf = wdata_i;
          if (is_plain) next_s.cmp_b_act = wdata_i;
        end
        `TM8_REG_FLAGS: begin
          // Already cleared before the tick logic
        end
        `TM8_REG_PINDIR: begin
          next_s.pin_dir = wdata_i[1:0];
        end
        default: begin
          next_s.pin_dir = s.pin_dir;
        end
      endcase
    end

    if (re_i) begin
      case (addr_i)
        `TM8_REG_CTRL: next_s.rdata = {2'h0, s.clock_select,
                                       s.waveform_mode_select};
        `TM8_REG_ACTION: next_s.rdata = {4'h0, s.compare_output_action_b,
                                         s.compare_output_action_a};
        `TM8_REG_COUNT: next_s.rdata = s.counter_value;
        `TM8_REG_CMPA: next_s.rdata = s.cmp_a_buf;
        `TM8_REG_CMPB: next_s.rdata = s.cmp_b_buf;
        `TM8_REG_FLAGS: next_s.rdata = {5'h00, s.flags};
        `TM8_REG_PINDIR: next_s.rdata = {6'h00, s.pin_dir};
        `TM8_REG_STATUS: next_s.rdata = {5'h00, s.dir, s.oc_b, s.oc_a};
        default: next_s.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o = s.rdata;
  assign compare_output_a_o = s.oc_a;
  assign compare_output_b_o = s.oc_b;
  // Pin shows the level only when directed out and overridden
  assign compare_output_a_oe_o = s.pin_dir[`TM8_PIN_A] &&
                                 (s.compare_output_action_a != `TM8_ACT_NONE);
  assign compare_output_b_oe_o = s.pin_dir[`TM8_PIN_B] &&
                                 (s.compare_output_action_b != `TM8_ACT_NONE);
  assign overflow_flag_o = s.flags[`TM8_FLAG_OVF];
  assign compare_flag_a_o = s.flags[`TM8_FLAG_CFA];
  assign compare_flag_b_o = s.flags[`TM8_FLAG_CFB];

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);

  a_normal_wrap: assert property (
    tick && !cnt_wr && s.waveform_mode_select == TM8_NORMAL &&
    s.counter_value == 8'hFF |=> s.counter_value == 8'h00)
    else $error("normal mode did not wrap");

  a_normal_ovf: assert property (
    tick && s.waveform_mode_select == TM8_NORMAL &&
    s.counter_value == 8'hFF |=> overflow_flag_o)
    else $error("overflow flag missed at wrap");

  a_ctc_clear: assert property (
    tick && !cnt_wr && s.waveform_mode_select == TM8_CTC && match_a
    |=> s.counter_value == 8'h00 && compare_flag_a_o)
    else $error("clear on match failed");

  a_fast_top: assert property (
    tick && !cnt_wr && is_fast && at_top
    |=> s.counter_value == 8'h00 && overflow_flag_o)
    else $error("fast mode top handling wrong");

  a_fast_set: assert property (
    tick && is_fast && at_top &&
    s.compare_output_action_a == `TM8_ACT_CLEAR |=> compare_output_a_o)
    else $error("fast output not set at wrap");

  a_fast_clear: assert property (
    tick && is_fast && match_a && !at_top &&
    s.compare_output_action_a == `TM8_ACT_CLEAR |=> !compare_output_a_o)
    else $error("fast output not cleared on match");

  a_pc_reverse: assert property (
    tick && !cnt_wr && is_pc && s.dir == TM8_UP && at_top &&
    s.counter_value != 8'h00
    |=> s.dir == TM8_DOWN && s.counter_value == $past(s.counter_value) - 8'h01)
    else $error("phase correct did not reverse at top");

  a_pc_ovf: assert property (
    tick && is_pc && s.dir == TM8_DOWN && at_bottom |=> overflow_flag_o)
    else $error("phase correct overflow missed");

  a_cmp_flag: assert property (
    tick && match_b |=> compare_flag_b_o)
    else $error("compare flag b not set");

  a_count_write: assert property (
    cnt_wr |=> s.counter_value == $past(wdata_i) && s.block)
    else $error("count write lost");

  a_stopped_hold: assert property (
    s.clock_select == 3'h0 && !cnt_wr [*2] |-> $stable(s.counter_value))
    else $error("counter moved while stopped");

  a_pin_enable: assert property (
    compare_output_a_oe_o |-> s.pin_dir[`TM8_PIN_A])
    else $error("pin driven while direction is input");

endmodule

// file: tm8_timer_tb_top.sv
// Self-checking testbench of the 8-bit waveform timer
`timescale 1ns/1ns
`include "tm8_consts.svh"
module tm8_timer_tb_top;
  import tm8_pkg::*;

  typedef struct {
    tm8_wgm_t m;
    logic [1:0] aa;
    logic [1:0] ab;
    logic [7:0] ca;
    logic [7:0] cb;
    int w;
    int ha;
    int hb;
  } tm8_row_t;

  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic [7:0] rdata_o;
  logic oc_a, oe_a, oc_b, oe_b, ovf, cfa, cfb;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  tm8_row_t rows [9];
  logic [7:0] d;
  int n, ha, hb, div;

  tm8_timer u_tm8_timer (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .we_i(we_i),
    .re_i(re_i),
    .rdata_o(rdata_o),
    .compare_output_a_o(oc_a),
    .compare_output_a_oe_o(oe_a),
    .compare_output_b_o(oc_b),
    .compare_output_b_oe_o(oe_b),
    .overflow_flag_o(ovf),
    .compare_flag_a_o(cfa),
    .compare_flag_b_o(cfb)
  );

  always #50 clock_i = ~clock_i;

  task automatic tally_and_finish();
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Ceiling well above the roughly 16000 cycles the sequence needs
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= v;
    we_i <= 1'b1;
    @(posedge clock_i);
    we_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe was taken
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clock_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clock_i);
    re_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask

  // Stop first so the count write and the new mode start together
  task automatic start(input tm8_wgm_t m, input logic [2:0] cs,
                       input logic [7:0] cnt);
    wr(`TM8_REG_CTRL, 8'h00);
    wr(`TM8_REG_FLAGS, 8'h07);
    wr(`TM8_REG_COUNT, cnt);
    wr(`TM8_REG_CTRL, {2'h0, cs, m});
  endtask

  // Window spans whole periods, so the high count ignores phase
  task automatic measure(input int w, output int a, output int b);
    a = 0;
    b = 0;
    repeat (w) begin
      @(negedge clock_i);
      if (oc_a === 1'b1) a++;
      if (oc_b === 1'b1) b++;
    end
  endtask

  initial begin
    rows = '{
      '{TM8_CTC, 2'h1, 2'h2, 8'h04, 8'h02, 20, 10, 0},
      '{TM8_NORMAL, 2'h3, 2'h1, 8'h64, 8'h07, 512, 512, 256},
      '{TM8_FAST_FF, 2'h2, 2'h3, 8'h3F, 8'h3F, 256, 64, 192},
      '{TM8_FAST_FF, 2'h2, 2'h2, 8'h00, 8'hFF, 256, 1, 256},
      '{TM8_PC_FF, 2'h2, 2'h3, 8'h64, 8'h64, 510, 200, 310},
      '{TM8_PC_FF, 2'h2, 2'h3, 8'h00, 8'h00, 510, 0, 510},
      '{TM8_PC_FF, 2'h3, 2'h2, 8'hFF, 8'hFF, 510, 0, 510},
      '{TM8_FAST_CMPA, 2'h1, 2'h2, 8'h09, 8'h04, 20, 10, 10},
      '{TM8_PC_CMPA, 2'h1, 2'h2, 8'h09, 8'h04, 36, 18, 16}
    };
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    rd(`TM8_REG_COUNT, d);
    chk("reset_count", 16'h0000, {8'h00, d});
    rd(`TM8_REG_CTRL, d);
    chk("reset_ctrl", 16'h0000, {8'h00, d});
    chk("reset_pins", 16'h0000,
        {9'h000, oc_a, oe_a, oc_b, oe_b, ovf, cfa, cfb});
    // Stopped timer keeps a written count
    wr(`TM8_REG_COUNT, 8'h5A);
    repeat (10) @(posedge clock_i);
    rd(`TM8_REG_COUNT, d);
    chk("stopped_count", 16'h005A, {8'h00, d});
    wr(`TM8_REG_PINDIR, 8'h03);
    foreach (rows[i]) begin
      wr(`TM8_REG_ACTION, {4'h0, rows[i].ab, rows[i].aa});
      wr(`TM8_REG_CMPA, rows[i].ca);
      wr(`TM8_REG_CMPB, rows[i].cb);
      start(rows[i].m, 3'h1, 8'h00);
      repeat (1200) @(posedge clock_i);
      measure(rows[i].w, ha, hb);
      chk("high_a", rows[i].ha[15:0], ha[15:0]);
      chk("high_b", rows[i].hb[15:0],
          hb[15:0]);
      chk("oe_a", {15'h0000, rows[i].aa != 2'h0}, {15'h0000, oe_a});
    end
    // Pin stays undriven while its direction is input
    wr(`TM8_REG_PINDIR, 8'h00);
    #1;
    chk("oe_off", 16'h0000, {14'h0000, oe_a, oe_b});
    // Each divisor: count FE needs two ticks to wrap and set the flag
    for (int cs = 1; cs <= 7; cs++) begin
      case (cs)
        1: div = 1;
        2: div = 8;
        3: div = 32;
        4: div = 64;
        5: div = 128;
        6: div = 256;
        default: div = 1024;
      endcase
      start(TM8_NORMAL, cs[2:0], 8'hFE);
      n = 0;
      while (ovf !== 1'b1 && n < 1100) begin
        @(posedge clock_i);
        #1;
        n++;
      end
      chk("ovf_delay", 16'h0001,
          {15'h0000, n >= div && n <= div + 3});
      if (cs == 7) begin
        rd(`TM8_REG_COUNT, d);
        chk("wrap_count", 16'h0000, {8'h00, d});
      end
    end
    // Flag is sticky until software clears it with a one
    wr(`TM8_REG_CTRL, 8'h00);
    repeat (5) @(posedge clock_i);
    chk("ovf_sticky", 16'h0001, {15'h0000, ovf});
    wr(`TM8_REG_FLAGS, 8'h01);
    #1;
    chk("ovf_clear", 16'h0000, {15'h0000, ovf});
    // Compare written below the count: match missed until after wrap
    wr(`TM8_REG_CMPA, 8'h10);
    start(TM8_CTC, 3'h1, 8'h20);
    repeat (200) @(posedge clock_i);
    chk("ctc_early", 16'h0000, {14'h0000, ovf, cfa});
    n = 0;
    while (ovf !== 1'b1 && n < 60) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    chk("ctc_ovf", 16'h0002, {14'h0000, ovf, cfa});
    repeat (20) @(posedge clock_i);
    #1;
    chk("ctc_cmp", 16'h0001, {15'h0000, cfa});
    // Compare A is top now, so the counter never wraps again
    wr(`TM8_REG_FLAGS, 8'h07);
    repeat (300) @(posedge clock_i);
    #1;
    chk("ctc_top", 16'h0001, {14'h0000, ovf, cfa});
    // Count written equal to compare: the next tick's match is blocked
    wr(`TM8_REG_CMPA, 8'h30);
    start(TM8_NORMAL, 3'h7, 8'h30);
    repeat (20) @(posedge clock_i);
    #1;
    chk("blocked_match", 16'h0000, {15'h0000, cfa});
    rd(`TM8_REG_COUNT, d);
    chk("count_moved", 16'h0031, {8'h00, d});
    // Mid-run reset: flag and pin enable are up before it
    wr(`TM8_REG_PINDIR, 8'h03);
    start(TM8_NORMAL, 3'h1, 8'hFE);
    repeat (4) @(posedge clock_i);
    chk("pre_reset", 16'h0003, {14'h0000, ovf, oe_a});
    reset_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    #1;
    chk("mid_reset_pins", 16'h0000,
        {9'h000, oc_a, oe_a, oc_b, oe_b, ovf, cfa, cfb});
    repeat (3) @(posedge clock_i);
    rd(`TM8_REG_COUNT, d);
    chk("mid_reset_count", 16'h0000, {8'h00, d});
    tally_and_finish();
  end
endmodule
